// [testbench.sv]
/*
  Self-checking bench for the external memory bus block.
  Assumes xmb_pkg, the checker bind and the SRAM model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xmb_pkg::*;
  logic clk, nrst, regWr, regRd, done, isExternal, en, clkEn, recovCycle;
  logic [1:0] regAddr;
  logic [7:0] regWdata, regRdata, rdata, adIn, portOut, portDir, portHighOut, portHighDir;
  xmb_req_t req;
  xmb_pins_t pins;
  int errorCnt = 0;
  int nTests = 0;

  xmb_external_memory_bus i_xmb_external_memory_bus (.clk(clk), .nrst(nrst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .req(req), .done(done), .isExternal(isExternal), .rdata(rdata),
    .adIn(adIn), .portOut(portOut), .portDir(portDir), .portHighOut(portHighOut),
    .portHighDir(portHighDir), .pins(pins));
  xmb_sram_model i_xmb_sram_model (.clk(clk), .pins(pins), .adIn(adIn));

  // Clock, and a watchdog that cuts a hang short
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #200000;
    errorCnt++;
    tally_and_finish();
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register port: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk("register", 16'(regRdata), 16'(exp));
  endtask
  task automatic cfg(input logic [7:0] m, input logic [7:0] e, input logic [7:0] s);
    wr(XMB_OFF_MCU, m);
    wr(XMB_OFF_EXT, e);
    wr(XMB_OFF_SFR, s);
    en = m[XMB_MCU_ENABLE_BIT];
    repeat (2) @(posedge clk);
    #1;
    chk("owned", 16'(pins.pinsOwned), 16'(en));
  endtask

  // One core access; lat 0 skips the cycle count, d is the expected data on reads
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic nr, input int lat);
    int n;
    logic ext;
    logic tail;
    logic [1:0] tailExp;
    n = 0;
    ext = en && (a >= XMB_EXT_BASE);
    @(posedge clk);
    req <= '{1'b1, w, a, d, nr};
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    if (n == 20)
    begin
      errorCnt++;
      tally_and_finish();
    end
    if (lat != 0)
      chk("latency", 16'(n), 16'(lat));
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    tail = pins.latchStrobe;
    chk("external", 16'(isExternal), 16'(ext));
    // Trailing pulse one cycle after done, or two with the recovery cycle
    @(posedge clk);
    #1;
    tailExp = recovCycle ? {1'b0, nr} : {nr, 1'b0};
    if (ext)
      chk("trailing latch", 16'({tail, pins.latchStrobe}), 16'(tailExp));
    if (!w && ext)
      chk("read data", 16'(rdata), 16'(d));
  endtask

  initial
  begin
    nrst = 1'b0;
    en = 1'b0;
    clkEn = 1'b1;
    recovCycle = 1'b0;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    req = '0;
    portOut = 8'h0f;
    portDir = 8'h00;
    portHighOut = 8'h00;
    portHighDir = 8'h00;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Reset values, then write and read back each control register
    for (int i = 0; i < 3; i++)
      rd(2'(i), 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(2'(i), 8'h5a ^ 8'(i));
      rd(2'(i), 8'h5a ^ 8'(i));
    end
    $display("test registers finished");
    // Disabled interface must not reach memory nor fold onto it
    cfg(8'h80, 8'h02, 8'h00);
    acc(1'b1, 16'h8000, 8'h11, 1'b0, 5);
    cfg(8'h00, 8'h02, 8'h00);
    acc(1'b1, 16'h8000, 8'h22, 1'b0, 0);
    cfg(8'h80, 8'h02, 8'h00);
    acc(1'b0, 16'h8000, 8'h11, 1'b1, 5);
    $display("test disable finished");
    // Every wait code in the single upper sector, write then read
    for (int c = 0; c < 4; c++)
    begin
      cfg({1'b1, 1'(c), 6'h00}, {6'h00, 1'(c >> 1), 1'b0}, 8'h00);
      recovCycle = (c == 3);
      acc(1'b1, 16'h4000 + 16'(c), 8'ha0 + 8'(c), 1'(c), 3 + (c > 1 ? 2 : c));
      acc(1'b0, 16'h4000 + 16'(c), 8'ha0 + 8'(c), !1'(c), 3 + (c > 1 ? 2 : c));
    end
    recovCycle = 1'b0;
    $display("test wait codes finished");
    // Split at 0x4000: lower one wait, upper none; limit zero means upper only
    cfg(8'h80, 8'h24, 8'h00);
    acc(1'b1, 16'h0260, 8'h31, 1'b0, 4);
    acc(1'b1, 16'h3fff, 8'h32, 1'b0, 4);
    acc(1'b1, 16'h4000, 8'h33, 1'b0, 3);
    cfg(8'h80, 8'h04, 8'h00);
    acc(1'b1, 16'h0300, 8'h34, 1'b0, 3);
    acc(1'b1, 16'h025f, 8'h35, 1'b0, 0);
    // Status is read-only: enable set, idle, last access internal
    wr(XMB_OFF_STS, 8'hff);
    rd(XMB_OFF_STS, 8'h01);
    $display("test sectors finished");
    // Keeper holds the last written byte, also with the interface off
    cfg(8'h80, 8'h00, 8'h40);
    acc(1'b1, 16'h4010, 8'h77, 1'b0, 3);
    chk("keeper value", 16'({pins.adOe, pins.adOut}), 16'hff77);
    cfg(8'h00, 8'h00, 8'h40);
    chk("keeper off", 16'({pins.adOe, pins.adOut}), 16'hff77);
    $display("test keeper finished");
    // High address pins released from the top down; pull-ups follow port bits
    for (int m = 0; m < 8; m += 7)
    begin
      cfg(8'h80, 8'h00, {2'b00, 3'(m), 3'b000});
      chk("high enables", 16'(pins.highOe), 16'(m == 7 ? 8'h00 : 8'hff >> m));
    end
    cfg(8'h80, 8'h00, 8'h18);
    chk("high enables", 16'(pins.highOe), 16'(8'h1f));
    chk("pull-ups", 16'(pins.adPullup), 16'(portOut));
    $display("test pins finished");
    // A frozen clock enable must drop a register write
    @(posedge clk);
    clkEn <= 1'b0;
    wr(XMB_OFF_MCU, 8'h00);
    @(posedge clk);
    clkEn <= 1'b1;
    rd(XMB_OFF_MCU, 8'h80);
    $display("test clock enable finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [xmb_external_memory_bus.sv]
/*
  External memory bus: turns core data-space accesses above the internal
  memory into multiplexed low address/data, high address, latch strobe
  and read/write strobes, with per-sector wait states and a bus keeper.
  Assumes the core holds its request until done pulses, that the core and
  register port share clk, and that an external latch captures the low
  address on the falling edge of the latch strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module xmb_external_memory_bus (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  input  wire logic [1:0]        regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [7:0]             regRdata,
  input  wire xmb_pkg::xmb_req_t req,
  output logic                   done,
  output logic                   isExternal,
  output logic [7:0]             rdata,
  input  wire logic [7:0]        adIn,
  input  wire logic [7:0]        portOut,
  input  wire logic [7:0]        portDir,
  input  wire logic [7:0]        portHighOut,
  input  wire logic [7:0]        portHighDir,
  output xmb_pkg::xmb_pins_t     pins
);
  import xmb_pkg::*;

  // Control registers
  logic [7:0] mcuControlReg;
  logic [7:0] extendedControlReg;
  logic [7:0] specialFunctionReg;

  // Bus engine state
  xmb_state_t state;
  xmb_state_t next_state;
  logic [1:0] waitCnt;
  logic [1:0] next_waitCnt;
  logic [1:0] curCode;
  logic       curWrite;
  logic       curExt;
  logic [15:0] curAddr;
  logic [7:0] curWdata;
  logic       latchQ;
  logic       readNQ;
  logic       writeNQ;
  logic [7:0] adOutQ;
  logic       adDriveQ;
  logic [7:0] keepVal;
  logic [7:0] rdataQ;
  logic       doneQ;
  // Read capture pipeline, matched to the two-flop input synchroniser
  logic       rdCap1;
  logic       rdCap2;

  // Pin input synchronisers for the muxed bus
  logic [7:0] adMeta;
  logic [7:0] adSync;

  // Field decode
  wire        xmemEnable     = mcuControlReg[XMB_MCU_ENABLE_BIT];
  wire        upperWaitLow   = mcuControlReg[XMB_MCU_UWAIT_LO];
  wire        upperWaitHigh  = extendedControlReg[XMB_EXT_UWAIT_HI];
  wire [1:0]  upperCode      = {upperWaitHigh, upperWaitLow};
  wire [1:0]  lowerCode      = extendedControlReg[XMB_EXT_LWAIT_LSB +: 2];
  wire [2:0]  sectorLimit    = extendedControlReg[XMB_EXT_LIMIT_LSB +: 3];
  wire        busKeeperEnable = specialFunctionReg[XMB_SFR_KEEPER_BIT];
  wire [2:0]  highMask       = specialFunctionReg[XMB_SFR_MASK_LSB +: 3];

  // Address decode: above the internal memory is external, never folded back
  wire        addrAbove   = req.addr >= XMB_EXT_BASE;
  wire        reqExternal = addrAbove & xmemEnable;
  wire [2:0]  addrSector  = req.addr[15:XMB_SECTOR_SHIFT];
  // A zero limit keeps everything in the upper sector
  wire        inUpper     = (sectorLimit == 3'h0) | (addrSector >= sectorLimit);
  wire [1:0]  reqCode     = inUpper ? upperCode : lowerCode;

  // High address pins released from the top down by the mask
  logic [7:0] highUsed;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_high
      // Code seven releases every line, not just the top seven
      assign highUsed[gi] = ((32'(gi) + 32'(highMask)) < 32'd8) &&
                            (highMask != 3'h7);
    end
  endgenerate

  // Register read mux
  wire [7:0] statusView = {4'h0, doneQ, curExt, (state != XMB_IDLE), xmemEnable};
  wire [7:0] readMux =
    (regAddr == XMB_OFF_MCU) ? mcuControlReg :
    (regAddr == XMB_OFF_EXT) ? extendedControlReg :
    (regAddr == XMB_OFF_SFR) ? specialFunctionReg : statusView;

  // Register writes; status is read-only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mcuControlReg      <= XMB_RST_MCU;
      extendedControlReg <= XMB_RST_EXT;
      specialFunctionReg <= XMB_RST_SFR;
      regRdata           <= 8'h00;
    end
    else if (clkEn)
    begin
      if (regWr && regAddr == XMB_OFF_MCU)
        mcuControlReg <= regWdata;
      if (regWr && regAddr == XMB_OFF_EXT)
        extendedControlReg <= regWdata;
      if (regWr && regAddr == XMB_OFF_SFR)
        specialFunctionReg <= regWdata;
      regRdata <= regRd ? readMux : 8'h00;
    end
  end

  // Two-flop synchroniser: only the second stage is read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      adMeta <= 8'h00;
      adSync <= 8'h00;
    end
    else if (clkEn)
    begin
      adMeta <= adIn;
      adSync <= adMeta;
    end
  end

  // Next-state logic of the bus cycle
  always_comb
  begin
    next_state   = state;
    next_waitCnt = waitCnt;
    case (state)
      XMB_IDLE:
        if (req.valid && !doneQ)
          next_state = XMB_ADDR;
      XMB_ADDR:
        next_state = XMB_STRB;
      XMB_STRB:
      begin
        // Wait states stretch the strobe phase
        next_waitCnt = (curCode == XMB_WAIT_NONE) ? 2'h0 :
                       (curCode == XMB_WAIT_ONE)  ? 2'h1 : 2'h2;
        next_state   = (curCode == XMB_WAIT_NONE) ? XMB_DONE : XMB_WAIT;
      end
      XMB_WAIT:
      begin
        next_waitCnt = waitCnt - 2'h1;
        if (waitCnt == 2'h1)
          next_state = XMB_DONE;
      end
      XMB_DONE:
        // Code three adds a recovery cycle before the next address
        next_state = (curCode == XMB_WAIT_REC) ? XMB_RECOV : XMB_IDLE;
      XMB_RECOV:
        next_state = XMB_IDLE;
      default:
        next_state = XMB_IDLE;
    endcase
  end

  // Strobe phase is where the read or write strobe is low
  wire inStrobe = (state == XMB_STRB) | (state == XMB_WAIT);
  wire enterDone = (state != XMB_DONE) & (next_state == XMB_DONE);

  // Sequencer registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= XMB_IDLE;
      waitCnt  <= 2'h0;
      curCode  <= XMB_WAIT_NONE;
      curWrite <= 1'b0;
      curExt   <= 1'b0;
      curAddr  <= 16'h0000;
      curWdata <= 8'h00;
    end
    else if (clkEn)
    begin
      state   <= next_state;
      waitCnt <= next_waitCnt;
      if (state == XMB_IDLE && req.valid && !doneQ)
      begin
        curCode  <= reqCode;
        curWrite <= req.write;
        curExt   <= reqExternal;
        curAddr  <= req.addr;
        curWdata <= req.wdata;
      end
    end
  end

  // Pin drive registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latchQ   <= 1'b0;
      readNQ   <= 1'b1;
      writeNQ  <= 1'b1;
      adOutQ   <= 8'h00;
      adDriveQ <= 1'b0;
      rdataQ   <= 8'h00;
      doneQ    <= 1'b0;
      rdCap1   <= 1'b0;
      rdCap2   <= 1'b0;
    end
    else if (clkEn)
    begin
      // Latch high in the address phase, low for the transfer
      // The trailing pulse follows the recovery cycle when code three is in use
      latchQ <= (next_state == XMB_ADDR) |
                ((state == XMB_RECOV || (state == XMB_DONE && next_state == XMB_IDLE))
                 & req.nextRam);
      // Strobes only toggle for external targets
      readNQ  <= !(curExt & !curWrite & (next_state == XMB_STRB || next_state == XMB_WAIT));
      writeNQ <= !(curExt & curWrite & (next_state == XMB_STRB || next_state == XMB_WAIT));
      // Low address first, then write data; released for a read
      if (next_state == XMB_ADDR)
      begin
        adOutQ   <= req.addr[7:0];
        adDriveQ <= 1'b1;
      end
      else if (next_state == XMB_STRB)
      begin
        adOutQ   <= curWdata;
        adDriveQ <= curWrite;
      end
      else if (next_state == XMB_IDLE || next_state == XMB_RECOV)
        adDriveQ <= 1'b0;
      // Sample the bus as it stood in the last strobe cycle; the synchroniser
      // delays it by two edges, so rdata trails done by two cycles
      rdCap1 <= enterDone & curExt & !curWrite;
      rdCap2 <= rdCap1;
      if (rdCap2)
        rdataQ <= adSync;
      doneQ <= enterDone;
    end
  end

  // Bus keeper tracks the last driven value, independent of the enable bit
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      keepVal <= 8'h00;
    else if (clkEn)
    begin
      if (xmemEnable && adDriveQ)
        keepVal <= adOutQ;
      else if (!xmemEnable && (portDir != 8'h00))
        keepVal <= (portOut & portDir) | (keepVal & ~portDir);
    end
  end

  // Pin ownership and output selection
  // Keeper never holds against the memory while the read strobe is low
  wire [7:0] adOeEnabled  = adDriveQ ? 8'hff :
                            ((busKeeperEnable && readNQ) ? 8'hff : 8'h00);
  wire [7:0] adValEnabled = adDriveQ ? adOutQ : keepVal;
  wire [7:0] adOeDisabled = portDir | (busKeeperEnable ? ~portDir : 8'h00);
  wire [7:0] adValDisabled = (portOut & portDir) | (keepVal & ~portDir);

  // Interface overrides the port direction when enabled
  assign pins.pinsOwned    = xmemEnable;
  assign pins.adOut        = xmemEnable ? adValEnabled : adValDisabled;
  assign pins.adOe         = xmemEnable ? adOeEnabled : adOeDisabled;
  // Pull-ups follow port bits on released lines; software clears them before sleep
  assign pins.adPullup     = portOut & ~portDir & ~pins.adOe;
  assign pins.highOut      = (xmemEnable ? (curAddr[15:8] & highUsed)
                                         : 8'h00) |
                             (portHighOut & ~(xmemEnable ? highUsed : 8'h00));
  assign pins.highOe       = xmemEnable ? (highUsed | portHighDir) : portHighDir;
  assign pins.latchStrobe  = xmemEnable & latchQ;
  assign pins.readStrobeN  = !xmemEnable | readNQ;
  assign pins.writeStrobeN = !xmemEnable | writeNQ;

  // Core-side answers
  assign done       = doneQ;
  assign isExternal = curExt;
  assign rdata      = rdataQ;

endmodule
`default_nettype wire

// [xmb_pkg.sv]
/*
  Package for the external memory bus block: register offsets, field
  positions, reset values, timing constants, state encoding and the
  carrier structs shared by the block and its surroundings.
  Assumes a single 250 MHz system clock and an 8-bit register port.
*/
package xmb_pkg;

  // Register offsets on the plain register port
  localparam logic [1:0] XMB_OFF_MCU = 2'h0;
  localparam logic [1:0] XMB_OFF_EXT = 2'h1;
  localparam logic [1:0] XMB_OFF_SFR = 2'h2;
  localparam logic [1:0] XMB_OFF_STS = 2'h3;

  // Reset values
  localparam logic [7:0] XMB_RST_MCU = 8'h00;
  localparam logic [7:0] XMB_RST_EXT = 8'h00;
  localparam logic [7:0] XMB_RST_SFR = 8'h00;

  // Field positions in mcu_control_reg
  localparam int XMB_MCU_ENABLE_BIT = 7;
  localparam int XMB_MCU_UWAIT_LO   = 6;
  // Field positions in extended_control_reg
  localparam int XMB_EXT_LIMIT_LSB  = 4;
  localparam int XMB_EXT_LWAIT_LSB  = 2;
  localparam int XMB_EXT_UWAIT_HI   = 1;
  // Field positions in special_function_reg
  localparam int XMB_SFR_KEEPER_BIT = 6;
  localparam int XMB_SFR_MASK_LSB   = 3;

  // Internal memory boundary and sector step
  localparam logic [15:0] XMB_EXT_BASE    = 16'h0260;
  localparam int          XMB_SECTOR_SHIFT = 13;

  // Wait codes
  localparam logic [1:0] XMB_WAIT_NONE = 2'h0;
  localparam logic [1:0] XMB_WAIT_ONE  = 2'h1;
  localparam logic [1:0] XMB_WAIT_TWO  = 2'h2;
  localparam logic [1:0] XMB_WAIT_REC  = 2'h3;

  // Bus cycle phases, Gray coded from XMB_IDLE through XMB_WAIT to XMB_DONE
  typedef enum logic [2:0] {
    XMB_IDLE  = 3'b000,
    XMB_ADDR  = 3'b001,
    XMB_STRB  = 3'b011,
    XMB_WAIT  = 3'b010,
    XMB_DONE  = 3'b110,
    XMB_RECOV = 3'b111
  } xmb_state_t;

  // Core side access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        nextRam;
  } xmb_req_t;

  // Pin group of the external bus
  typedef struct packed {
    logic [7:0] adOut;
    logic [7:0] adOe;
    logic [7:0] adPullup;
    logic [7:0] highOut;
    logic [7:0] highOe;
    logic       latchStrobe;
    logic       readStrobeN;
    logic       writeStrobeN;
    logic       pinsOwned;
  } xmb_pins_t;

endpackage

// [xmb_props.sv]
/*
  Port checker for the external memory bus block.
  Assumes one clock, async active-low reset and the xmb_pkg carriers.
*/
`timescale 1ns/1ps
`default_nettype none
module xmb_props (
  input wire logic               clk,
  input wire logic               nrst,
  input wire xmb_pkg::xmb_req_t  req,
  input wire logic               done,
  input wire logic [7:0]         portHighOut,
  input wire logic [7:0]         portHighDir,
  input wire xmb_pkg::xmb_pins_t pins
);
  import xmb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Strobe qualifiers; internal targets must never see a strobe
  wire extReq = req.valid && (req.addr >= XMB_EXT_BASE) && pins.pinsOwned;
  wire strbOn = !(pins.readStrobeN && pins.writeStrobeN);

  // Address phase: latch high outside the done cycle, then low
  sequence addr_phase;
    extReq && pins.latchStrobe && !done ##1 !pins.latchStrobe;
  endsequence
  // Longest stretch of the strobe, two wait cycles
  sequence strb_long;
    strbOn [*3];
  endsequence

  latch_addr_a: assert property (addr_phase |-> $past(pins.adOut) == req.addr[7:0])
    else $error("low address not on bus at latch fall");
  strb_xfer_a: assert property (strbOn |-> extReq && !pins.latchStrobe)
    else $error("strobe outside an external transfer");
  rd_dir_a: assert property (!pins.readStrobeN |-> !req.write && pins.writeStrobeN)
    else $error("read strobe on a write");
  wr_data_a: assert property (!pins.writeStrobeN |-> pins.adOut == req.wdata && &pins.adOe)
    else $error("write data not driven under strobe");
  strb_len_a: assert property (strb_long |=> !strbOn)
    else $error("strobe longer than three cycles");
  strb_end_a: assert property ($rose(!strbOn) |-> done)
    else $error("strobe end without done");
  done_bound_a: assert property ($rose(req.valid) |-> ##[3:6] done)
    else $error("access not finished in time");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  high_port_a: assert property (!pins.pinsOwned |->
    pins.highOe == portHighDir && pins.highOut == portHighOut)
    else $error("high lines not with the port while disabled");
endmodule

bind xmb_external_memory_bus xmb_props i_xmb_props (
  .clk(clk), .nrst(nrst), .req(req), .done(done),
  .portHighOut(portHighOut), .portHighDir(portHighDir), .pins(pins)
);
`default_nettype wire

// [xmb_sram_model.sv]
/*
  Behavioural external SRAM behind a transparent address latch.
  Assumes the block's pin group; clk only paces the floating-bus pattern.
*/
`timescale 1ns/1ps
`default_nettype none
module xmb_sram_model (
  input wire logic               clk,
  input wire xmb_pkg::xmb_pins_t pins,
  output logic [7:0]             adIn
);
  import xmb_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [7:0]  latchQ;
  logic [7:0]  wrData;
  logic [7:0]  lastBus = 8'h00;
  // Board wiring delay gives the latch its address hold after the fall
  wire  [7:0]  adLate;
  assign #1 adLate = pins.adOut;
  logic [15:0] curAddr;
  wire         strb     = !(pins.readStrobeN && pins.writeStrobeN);
  wire         memDrive = !pins.readStrobeN;

  // Latch is transparent while the strobe is high, holds after the fall
  always_latch if (pins.latchStrobe) latchQ = adLate;
  // Strobe-timed only, no clock phase assumed; held so edge races cannot hurt
  always_latch if (strb) curAddr = {pins.highOut & pins.highOe, latchQ};
  always_latch if (!pins.writeStrobeN) wrData = pins.adOut;
  always @(posedge pins.writeStrobeN) mem[curAddr] <= wrData;
  // Data only while read strobe is low; a released line shows pull-up or a toggling level
  assign adIn = (pins.adOe & pins.adOut) | (~pins.adOe &
    (memDrive ? mem[curAddr] : (pins.adPullup | ~lastBus)));
  always @(posedge clk) lastBus <= adIn;
endmodule
`default_nettype wire
